// file: pkg/dss_pkg.sv
// Shared constants for the status, shift and multiply slice
package dss_pkg;
  // Widths
  localparam int DATA_W = 16;
  localparam int ACC_W  = 32;
  // Largest scaling shift
  localparam logic [4:0] MAX_SHIFT = 5'h10;
  // Set/clear control selectors
  localparam logic [1:0] CTRL_SAT  = 2'h0;
  localparam logic [1:0] CTRL_SIGN = 2'h1;
  localparam logic [1:0] CTRL_EXT  = 2'h2;
  localparam logic [1:0] CTRL_TST  = 2'h3;
  // Product shift codes
  localparam logic [1:0] PSH_NONE   = 2'h0;
  localparam logic [1:0] PSH_LEFT1  = 2'h1;
  localparam logic [1:0] PSH_LEFT4  = 2'h2;
  localparam logic [1:0] PSH_RIGHT6 = 2'h3;
  // Product shift amounts
  localparam int PSH_L1_AMT = 1;
  localparam int PSH_L4_AMT = 4;
  localparam int PSH_R6_AMT = 6;
  // Field positions in the two status words
  localparam int W0_OVF_BIT  = 12;
  localparam int W0_SAT_BIT  = 11;
  localparam int W1_TST_BIT  = 11;
  localparam int W1_SIGN_BIT = 10;
  localparam int W1_PSH_LSB  = 0;
  // Reset values
  localparam logic       RST_OVF  = 1'b0;
  localparam logic       RST_SAT  = 1'b0;
  localparam logic       RST_SIGN = 1'b1;
  localparam logic       RST_EXT  = 1'b1;
  localparam logic       RST_TST  = 1'b0;
  localparam logic [1:0] RST_PSH  = 2'h0;
  // Saturation limits
  localparam logic [31:0] SAT_POS = 32'h7fffffff;
  localparam logic [31:0] SAT_NEG = 32'h80000000;
  // Arithmetic operations
  typedef enum logic [1:0] {
    DSS_ALU_NONE = 2'b00,
    DSS_ALU_LOAD = 2'b01,
    DSS_ALU_ADD  = 2'b10,
    DSS_ALU_SUB  = 2'b11
  } dss_alu_op_t;
endpackage : dss_pkg

// file: pkg/dss_mul_if.sv
`timescale 1ns/1ps
// Link between the core slice and its multiplier
interface dss_mul_if;
  logic        load_operand; // Load operand register
  logic        start;        // Multiply this cycle
  logic        is_unsigned;  // Unsigned multiply
  logic [15:0] data;         // Data bus word
  logic [15:0] operand;      // Operand register contents
  logic [31:0] product;      // Product register contents
  // Core side
  modport core (
    output load_operand,
    output start,
    output is_unsigned,
    output data,
    input  operand,
    input  product
  );
  // Multiplier side
  modport mul (
    input  load_operand,
    input  start,
    input  is_unsigned,
    input  data,
    output operand,
    output product
  );
endinterface : dss_mul_if

// file: logic/dss_multiplier.sv
`timescale 1ns/1ps
// 16x16 multiplier with operand and product registers
module dss_multiplier (
  input wire logic clk_sys,
  input wire logic rst_b,
  dss_mul_if.mul   mif
);
  logic [31:0] ext_a;        // Extended operand register
  logic [31:0] ext_b;        // Extended data word
  logic [31:0] prod_next;    // Full product
  logic [15:0] operand_reg;  // Operand register
  logic [31:0] product_reg;  // Product register

  // Extend both factors, sign or zero by mode
  always_comb
  begin
    if (mif.is_unsigned)
    begin
      ext_a = {16'h0000, operand_reg};
      ext_b = {16'h0000, mif.data};
    end
    else
    begin
      // Two's-complement factors
      ext_a = {{16{operand_reg[15]}}, operand_reg};
      ext_b = {{16{mif.data[15]}}, mif.data};
    end
    // Low 32 bits of product are exact for both modes
    prod_next = ext_a * ext_b;
  end

  // Operand register load
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      operand_reg <= 16'h0000;
    else if (mif.load_operand)
      operand_reg <= mif.data;
  end

  // Product register, touched only by a multiply
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      product_reg <= 32'h00000000;
    else if (mif.start)
      product_reg <= prod_next;
  end

  assign mif.operand = operand_reg;
  assign mif.product = product_reg;

  // Signed product lands one cycle later
  property p_signed_mul;
    @(posedge clk_sys) disable iff (!rst_b)
    (mif.start && !mif.is_unsigned) |=> $signed(product_reg) ==
      $signed($past(operand_reg)) * $signed($past(mif.data));
  endproperty
  a_signed_mul: assert property (p_signed_mul) else $error("Signed product wrong");

  // Product holds without a multiply
  property p_prod_hold;
    @(posedge clk_sys) disable iff (!rst_b)
    !mif.start |=> $stable(product_reg);
  endproperty
  a_prod_hold: assert property (p_prod_hold) else $error("Product changed");
endmodule : dss_multiplier

// file: logic/dss_core.sv
`timescale 1ns/1ps
module dss_core #(
  parameter int DATA_W = dss_pkg::DATA_W,
  parameter int ACC_W  = dss_pkg::ACC_W
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic              set_control_instr,
  input  wire logic              clear_control_instr,
  input  wire logic [1:0]        ctrl_sel,
  input  wire logic              status_load_instr,
  input  wire logic              status_load_word,
  input  wire logic              set_product_mode_instr,
  input  wire logic [1:0]        product_mode_in,
  input  wire logic              conditional_branch_instr,
  input  wire logic              bit_test_instr,
  input  wire logic              bit_test_by_operand_instr,
  input  wire logic [3:0]        bit_pos_imm,
  input  wire logic              aux_compare_instr,
  input  wire logic              aux_compare_met,
  input  wire logic              normalize_instr,
  input  wire logic              branch_on_test_set,
  input  wire dss_pkg::dss_alu_op_t alu_op,
  input  wire logic              alu_from_product,
  input  wire logic              add_no_extend_instr,
  input  wire logic              shift_from_operand,
  input  wire logic [4:0]        shift_imm,
  input  wire logic              load_operand,
  input  wire logic              multiply,
  input  wire logic              unsigned_multiply,
  output logic                   overflow_flag,
  output logic                   saturate_mode_bit,
  output logic [1:0]             product_shift_field,
  output logic                   sign_extend_mode,
  output logic                   test_control_flag,
  output logic                   ext_flag_pin,
  output logic                   test_branch_take,
  output logic [ACC_W-1:0]       accumulator,
  output logic [ACC_W-1:0]       product_reg,
  output logic [DATA_W-1:0]      multiplier_operand_reg,
  output logic [ACC_W-1:0]       product_scaled,
  output logic [ACC_W-1:0]       scaled_operand
);
  dss_mul_if mif ();                     // Multiplier link
  logic [ACC_W-1:0]  acc_reg;            // Accumulator
  logic [ACC_W-1:0]  acc_next;           // Accumulator next value
  logic              ovf_reg;            // Overflow flag
  logic              sat_reg;            // Saturate mode
  logic [1:0]        psh_reg;            // Product shift field
  logic              sign_reg;           // Sign-extension mode
  logic              tst_reg;            // Test/control flag
  logic              ext_reg;            // External flag
  logic [4:0]        shift_amt;          // Scaling shift count
  logic [ACC_W-1:0]  ext_word;           // Extended data word
  logic [ACC_W-1:0]  scaled;             // Scaler output
  logic [ACC_W-1:0]  pscaled;            // Product path output
  logic [ACC_W-1:0]  alu_b;              // Second arithmetic operand
  logic [ACC_W-1:0]  alu_res;            // Raw arithmetic result
  logic              alu_ovf;            // Overflow this cycle
  logic              sign_use;           // Effective sign extension
  logic [3:0]        bit_pos;            // Tested bit position
  logic              tested_bit;         // Value of tested bit
  logic              is_w0_load;         // Status word zero load
  logic              is_w1_load;         // Status word one load

  // Multiplier hookup
  assign mif.load_operand = load_operand;
  assign mif.start        = multiply;
  assign mif.is_unsigned  = unsigned_multiply;
  assign mif.data         = data_in;

  dss_multiplier u_mul (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .mif     (mif)
  );

  assign is_w0_load = status_load_instr && !status_load_word;
  assign is_w1_load = status_load_instr && status_load_word;

  // Input scaling shifter, purely combinational
  always_comb
  begin
    // Count from instruction or operand register
    if (shift_from_operand)
      shift_amt = {1'b0, mif.operand[3:0]};
    else if (shift_imm > dss_pkg::MAX_SHIFT)
      shift_amt = dss_pkg::MAX_SHIFT;     // Clamp illegal counts
    else
      shift_amt = shift_imm;
    // No-extend add forces zero extension
    sign_use = sign_reg && !add_no_extend_instr;
    if (sign_use)
      ext_word = {{(ACC_W-DATA_W){data_in[DATA_W-1]}}, data_in};
    else
      ext_word = {{(ACC_W-DATA_W){1'b0}}, data_in};
    // Left shift fills low bits with zero
    scaled = ext_word << shift_amt;
  end

  // Product shift on the way out only
  always_comb
  begin
    case (psh_reg)
      dss_pkg::PSH_NONE:
        pscaled = mif.product;
      dss_pkg::PSH_LEFT1:
        pscaled = mif.product << dss_pkg::PSH_L1_AMT;
      dss_pkg::PSH_LEFT4:
        pscaled = mif.product << dss_pkg::PSH_L4_AMT;
      dss_pkg::PSH_RIGHT6:
        pscaled = $unsigned($signed(mif.product) >>> dss_pkg::PSH_R6_AMT);
      default:
        pscaled = mif.product;
    endcase
  end

  // Arithmetic and overflow detection
  always_comb
  begin
    alu_b = alu_from_product ? pscaled : scaled;
    alu_res = acc_reg;
    alu_ovf = 1'b0;
    case (alu_op)
      dss_pkg::DSS_ALU_LOAD:
        alu_res = alu_b;
      dss_pkg::DSS_ALU_ADD:
      begin
        alu_res = acc_reg + alu_b;
        alu_ovf = (acc_reg[ACC_W-1] == alu_b[ACC_W-1]) &&
                  (alu_res[ACC_W-1] != acc_reg[ACC_W-1]);
      end
      dss_pkg::DSS_ALU_SUB:
      begin
        alu_res = acc_reg - alu_b;
        alu_ovf = (acc_reg[ACC_W-1] != alu_b[ACC_W-1]) &&
                  (alu_res[ACC_W-1] != acc_reg[ACC_W-1]);
      end
      default:
        alu_res = acc_reg;
    endcase
    // Wrap or clamp; wrapped sign is opposite of true sign
    if (alu_ovf && sat_reg)
      acc_next = alu_res[ACC_W-1] ? dss_pkg::SAT_POS : dss_pkg::SAT_NEG;
    else
      acc_next = alu_res;
  end

  // Accumulator register
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      acc_reg <= '0;
    else if (alu_op != dss_pkg::DSS_ALU_NONE)
      acc_reg <= acc_next;
  end

  // Sticky overflow flag; a new overflow beats any clear
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      ovf_reg <= dss_pkg::RST_OVF;
    else if (alu_ovf)
      ovf_reg <= 1'b1;
    else if (is_w0_load)
      ovf_reg <= data_in[dss_pkg::W0_OVF_BIT];
    else if (conditional_branch_instr)
      ovf_reg <= 1'b0;
  end

  // Saturate mode bit
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      sat_reg <= dss_pkg::RST_SAT;
    else if (set_control_instr && ctrl_sel == dss_pkg::CTRL_SAT)
      sat_reg <= 1'b1;
    else if (clear_control_instr && ctrl_sel == dss_pkg::CTRL_SAT)
      sat_reg <= 1'b0;
    else if (is_w0_load)
      sat_reg <= data_in[dss_pkg::W0_SAT_BIT];
  end

  // Sign-extension mode bit
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      sign_reg <= dss_pkg::RST_SIGN;
    else if (set_control_instr && ctrl_sel == dss_pkg::CTRL_SIGN)
      sign_reg <= 1'b1;
    else if (clear_control_instr && ctrl_sel == dss_pkg::CTRL_SIGN)
      sign_reg <= 1'b0;
    else if (is_w1_load)
      sign_reg <= data_in[dss_pkg::W1_SIGN_BIT];
  end

  // Product shift field
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      psh_reg <= dss_pkg::RST_PSH;
    else if (set_product_mode_instr)
      psh_reg <= product_mode_in;
    else if (is_w1_load)
      psh_reg <= data_in[dss_pkg::W1_PSH_LSB +: 2];
  end

  // External flag bit, straight to the pin
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      ext_reg <= dss_pkg::RST_EXT;
    else if (set_control_instr && ctrl_sel == dss_pkg::CTRL_EXT)
      ext_reg <= 1'b1;
    else if (clear_control_instr && ctrl_sel == dss_pkg::CTRL_EXT)
      ext_reg <= 1'b0;
  end

  // Tested bit from immediate or operand register
  assign bit_pos    = bit_test_by_operand_instr ? mif.operand[3:0] : bit_pos_imm;
  assign tested_bit = data_in[bit_pos];

  // Test/control flag
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      tst_reg <= dss_pkg::RST_TST;
    else if (set_control_instr && ctrl_sel == dss_pkg::CTRL_TST)
      tst_reg <= 1'b1;
    else if (clear_control_instr && ctrl_sel == dss_pkg::CTRL_TST)
      tst_reg <= 1'b0;
    else if (bit_test_instr || bit_test_by_operand_instr)
      tst_reg <= tested_bit;
    else if (aux_compare_instr)
      tst_reg <= aux_compare_met;
    else if (normalize_instr)
      tst_reg <= acc_reg[ACC_W-1] ^ acc_reg[ACC_W-2];
    else if (is_w1_load)
      tst_reg <= data_in[dss_pkg::W1_TST_BIT];
  end

  // Outputs
  assign overflow_flag          = ovf_reg;
  assign saturate_mode_bit      = sat_reg;
  assign product_shift_field    = psh_reg;
  assign sign_extend_mode       = sign_reg;
  assign test_control_flag      = tst_reg;
  assign ext_flag_pin           = ext_reg;
  assign test_branch_take       = (tst_reg == branch_on_test_set);
  assign accumulator            = acc_reg;
  assign product_reg            = mif.product;
  assign multiplier_operand_reg = mif.operand;
  assign product_scaled         = pscaled;
  assign scaled_operand         = scaled;

  // Overflow sets the flag next cycle, saturating or not
  property p_ovf_set;
    @(posedge clk_sys) disable iff (!rst_b)
    alu_ovf |=> ovf_reg;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("Overflow flag not set");

  // Flag stays up without a clearing instruction
  property p_ovf_hold;
    @(posedge clk_sys) disable iff (!rst_b)
    ovf_reg && !conditional_branch_instr && !is_w0_load |=> ovf_reg;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("Overflow flag dropped");

  // Positive saturation clamps accumulator
  property p_sat_pos;
    @(posedge clk_sys) disable iff (!rst_b)
    alu_ovf && sat_reg && alu_res[ACC_W-1] |=> acc_reg == 32'h7fffffff;
  endproperty
  a_sat_pos: assert property (p_sat_pos) else $error("No positive clamp");

  // Wrap mode keeps raw result
  property p_wrap;
    @(posedge clk_sys) disable iff (!rst_b)
    alu_ovf && !sat_reg |=> acc_reg == $past(alu_res);
  endproperty
  a_wrap: assert property (p_wrap) else $error("Wrap result altered");

  // Right-six mode fills top with sign
  property p_psh_r6;
    @(posedge clk_sys) disable iff (!rst_b)
    psh_reg == 2'h3 |-> pscaled[31:26] == {6{mif.product[31]}} && pscaled[25:0] == mif.product[31:6];
  endproperty
  a_psh_r6: assert property (p_psh_r6) else $error("Right shift wrong");

  // Low bits below shift count are zero
  property p_scale_low;
    @(posedge clk_sys) disable iff (!rst_b)
    shift_amt == 5'h4 |-> scaled[3:0] == 4'h0 && scaled[19:4] == data_in;
  endproperty
  a_scale_low: assert property (p_scale_low) else $error("Scaler low fill wrong");

  // No-extend add zero fills upper bits
  property p_no_ext;
    @(posedge clk_sys) disable iff (!rst_b)
    add_no_extend_instr && shift_amt == 5'h0 |-> scaled[31:16] == 16'h0000;
  endproperty
  a_no_ext: assert property (p_no_ext) else $error("Extension not suppressed");

  // Clearing the pin flag drops the pin
  property p_ext_clr;
    @(posedge clk_sys) disable iff (!rst_b)
    clear_control_instr && !set_control_instr && ctrl_sel == 2'h2 |=> !ext_flag_pin;
  endproperty
  a_ext_clr: assert property (p_ext_clr) else $error("Pin flag not cleared");

  // Set-mode instruction loads product field
  property p_psh_load;
    @(posedge clk_sys) disable iff (!rst_b)
    set_product_mode_instr |=> psh_reg == $past(product_mode_in);
  endproperty
  a_psh_load: assert property (p_psh_load) else $error("Product field not loaded");
endmodule : dss_core

// file: tb/dss_decoder_model.sv
`timescale 1ns/1ps
// Decoder stand-in: turns one op code a cycle into the slice's controls
module dss_decoder_model (
  output logic [15:0]          data_in,
  output logic                 set_control_instr,
  output logic                 clear_control_instr,
  output logic [1:0]           ctrl_sel,
  output logic                 status_load_instr,
  output logic                 status_load_word,
  output logic                 set_product_mode_instr,
  output logic [1:0]           product_mode_in,
  output logic                 conditional_branch_instr,
  output logic                 bit_test_instr,
  output logic                 bit_test_by_operand_instr,
  output logic [3:0]           bit_pos_imm,
  output logic                 aux_compare_instr,
  output logic                 aux_compare_met,
  output logic                 normalize_instr,
  output logic                 branch_on_test_set,
  output dss_pkg::dss_alu_op_t alu_op,
  output logic                 alu_from_product,
  output logic                 add_no_extend_instr,
  output logic                 shift_from_operand,
  output logic [4:0]           shift_imm,
  output logic                 load_operand,
  output logic                 multiply,
  output logic                 unsigned_multiply
);
  // Decode one op; caller applies it just after a rising edge
  task automatic drive(input int unsigned k, input logic [15:0] d, input logic [4:0] a, input logic [1:0] s);
    begin
      // Every pulse low unless this op raises it
      {set_control_instr, clear_control_instr, status_load_instr, set_product_mode_instr} = 4'h0;
      {conditional_branch_instr, bit_test_instr, bit_test_by_operand_instr, aux_compare_instr} = 4'h0;
      {normalize_instr, load_operand, multiply, unsigned_multiply, alu_from_product} = 5'h00;
      {add_no_extend_instr, shift_from_operand} = 2'h0;
      alu_op = dss_pkg::DSS_ALU_NONE;
      data_in = d;
      ctrl_sel = s;
      product_mode_in = s;
      status_load_word = (k == 4);
      bit_pos_imm = a[3:0];
      aux_compare_met = a[0];
      branch_on_test_set = a[4];
      shift_imm = a;
      case (k)
        1: set_control_instr = 1'b1;
        2: clear_control_instr = 1'b1;
        3, 4: status_load_instr = 1'b1;
        5: set_product_mode_instr = 1'b1;
        6: conditional_branch_instr = 1'b1;
        7: bit_test_instr = 1'b1;
        8: bit_test_by_operand_instr = 1'b1;
        9: aux_compare_instr = 1'b1;
        10: normalize_instr = 1'b1;
        11: load_operand = 1'b1;
        12, 13:
        begin
          multiply = 1'b1;
          unsigned_multiply = (k == 13);
        end
        default:
        begin
          // Arithmetic ops: 14..16 from scaler, 17..19 from product
          if (k >= 14)
          begin
            alu_op = dss_pkg::dss_alu_op_t'(2'(k >= 17 ? k - 16 : k - 13));
            alu_from_product = (k >= 17);
            {shift_from_operand, add_no_extend_instr} = s;
          end
        end
      endcase
    end
  endtask : drive
endmodule : dss_decoder_model

// file: tb/dss_core_test.sv
`timescale 1ns/1ps
// Self-checking bench for the status, shift and multiply slice
module dss_core_test;
  logic                 clk_sys, rst_b;
  logic [15:0]          data_in, multiplier_operand_reg, e_opnd;
  logic [1:0]           ctrl_sel, product_mode_in, product_shift_field, e_psh;
  logic [3:0]           bit_pos_imm;
  logic [4:0]           shift_imm;
  dss_pkg::dss_alu_op_t alu_op;
  logic                 set_control_instr, clear_control_instr, status_load_instr, status_load_word;
  logic                 set_product_mode_instr, conditional_branch_instr, bit_test_instr, normalize_instr;
  logic                 bit_test_by_operand_instr, aux_compare_instr, aux_compare_met, branch_on_test_set;
  logic                 alu_from_product, add_no_extend_instr, shift_from_operand;
  logic                 load_operand, multiply, unsigned_multiply, ext_flag_pin, test_branch_take;
  logic                 overflow_flag, saturate_mode_bit, sign_extend_mode, test_control_flag;
  logic [31:0]          accumulator, product_reg, product_scaled, scaled_operand, e_acc, e_prod;
  logic                 e_ovf, e_sat, e_sign, e_tst, e_ext; // Expected flags
  int                   fail_count = 0;
  int                   samples_checked = 0;

  // Far side: instruction decoder
  dss_decoder_model u_dss_decoder_model (.data_in, .set_control_instr, .clear_control_instr, .ctrl_sel,
    .status_load_instr, .status_load_word, .set_product_mode_instr, .product_mode_in, .conditional_branch_instr,
    .bit_test_instr, .bit_test_by_operand_instr, .bit_pos_imm, .aux_compare_instr, .aux_compare_met,
    .normalize_instr, .branch_on_test_set, .alu_op, .alu_from_product, .add_no_extend_instr,
    .shift_from_operand, .shift_imm, .load_operand, .multiply, .unsigned_multiply);
  // Slice under test
  dss_core u_dss_core (.clk_sys, .rst_b, .data_in, .set_control_instr, .clear_control_instr, .ctrl_sel,
    .status_load_instr, .status_load_word, .set_product_mode_instr, .product_mode_in, .conditional_branch_instr,
    .bit_test_instr, .bit_test_by_operand_instr, .bit_pos_imm, .aux_compare_instr, .aux_compare_met,
    .normalize_instr, .branch_on_test_set, .alu_op, .alu_from_product, .add_no_extend_instr,
    .shift_from_operand, .shift_imm, .load_operand, .multiply, .unsigned_multiply, .overflow_flag,
    .saturate_mode_bit, .product_shift_field, .sign_extend_mode, .test_control_flag, .ext_flag_pin,
    .test_branch_take, .accumulator, .product_reg, .multiplier_operand_reg, .product_scaled, .scaled_operand);

  // Expected scaler output
  function automatic logic [31:0] f_scale(input logic [15:0] d, input logic [4:0] sh, input logic sx);
    return (sx ? {{16{d[15]}}, d} : {16'h0000, d}) << sh;
  endfunction : f_scale

  // Expected product path output
  function automatic logic [31:0] f_pscale(input logic [31:0] p, input logic [1:0] m);
    case (m)
      2'h1: return p << 1;
      2'h2: return p << 4;
      2'h3: return $signed(p) >>> 6;
      default: return p;
    endcase
  endfunction : f_pscale

  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    begin
      samples_checked++;
      if (seen !== exp)
      begin
        fail_count++;
        $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask : check

  // All registered outputs against the expected state
  task automatic check_state();
    begin
      check("overflow_flag", overflow_flag, e_ovf);
      check("saturate_mode_bit", saturate_mode_bit, e_sat);
      check("product_shift_field", product_shift_field, e_psh);
      check("sign_extend_mode", sign_extend_mode, e_sign);
      check("test_control_flag", test_control_flag, e_tst);
      check("ext_flag_pin", ext_flag_pin, e_ext);
      check("accumulator", accumulator, e_acc);
      check("product_reg", product_reg, e_prod);
      check("multiplier_operand_reg", multiplier_operand_reg, e_opnd);
    end
  endtask : check_state

  // One op for one cycle, then predict its effect
  task automatic run(input int unsigned k, input logic [15:0] d, input logic [4:0] a, input logic [1:0] s);
    logic [1:0]  se;
    logic [4:0]  sh;
    logic [31:0] sc;
    logic [31:0] b;
    logic [32:0] r;
    begin
      @(posedge clk_sys);
      #1;
      check_state();
      u_dss_decoder_model.drive(k, d, a, s);
      #1;
      se = (k >= 14) ? s : 2'h0;
      sh = se[1] ? {1'b0, e_opnd[3:0]} : ((a > 5'h10) ? 5'h10 : a);
      sc = f_scale(d, sh, e_sign & ~se[0]);
      b = (k >= 17) ? f_pscale(e_prod, e_psh) : sc;
      check("scaled_operand", scaled_operand, sc);
      check("product_scaled", product_scaled, f_pscale(e_prod, e_psh));
      check("test_branch_take", test_branch_take, e_tst == a[4]);
      case (k)
        1, 2:
        begin
          case (s)
            2'h0: e_sat = (k == 1);
            2'h1: e_sign = (k == 1);
            2'h2: e_ext = (k == 1);
            default: e_tst = (k == 1);
          endcase
        end
        3: {e_ovf, e_sat} = d[12:11];
        4: {e_tst, e_sign, e_psh} = {d[11:10], d[1:0]};
        5: e_psh = s;
        6: e_ovf = 1'b0;
        7: e_tst = d[a[3:0]];
        8: e_tst = d[e_opnd[3:0]];
        9: e_tst = a[0];
        10: e_tst = e_acc[31] ^ e_acc[30];
        11: e_opnd = d;
        12: e_prod = {{16{e_opnd[15]}}, e_opnd} * {{16{d[15]}}, d};
        13: e_prod = {16'h0000, e_opnd} * {16'h0000, d};
        14, 17: e_acc = b;
        15, 16, 18, 19:
        begin
          r = (k == 15 || k == 18) ? {e_acc[31], e_acc} + {b[31], b} : {e_acc[31], e_acc} - {b[31], b};
          e_acc = r[31:0];
          // Overflow: flag always, clamp only in saturate mode
          if (r[32] != r[31])
          begin
            e_ovf = 1'b1;
            if (e_sat)
              e_acc = r[31] ? 32'h7fffffff : 32'h80000000;
          end
        end
      endcase
    end
  endtask : run

  // Reset held 12 cycles with a set pulse pending
  task automatic do_reset();
    begin
      rst_b = 1'b0;
      u_dss_decoder_model.drive(1, 16'hffff, 5'h00, 2'h0);
      {e_ovf, e_sat, e_psh, e_sign, e_tst, e_ext, e_acc, e_prod, e_opnd} = {6'h02, 1'b1, 80'h0};
      @(posedge clk_sys);
      #1;
      check_state();
      repeat (11) @(posedge clk_sys);
      #1;
      check_state();
      u_dss_decoder_model.drive(0, 16'h0000, 5'h00, 2'h0);
      rst_b = 1'b1;
    end
  endtask : do_reset

  // Verdict and end of run
  task automatic conclude();
    begin
      if (fail_count == 0 && samples_checked > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask : conclude

  // 100 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Hang guard
  initial
  begin
    #500000;
    fail_count++;
    conclude();
  end

  // Main sequence
  initial
  begin
    void'($urandom(68));
    do_reset();
    for (int i = 0; i < 4; i++)
    begin
      run(2, 16'h0000, 5'h00, 2'(i));
      run(1, 16'h0000, 5'h00, 2'(i));
      run(11, 16'h000f, 5'h00, 2'h0);
      run(14, 16'h8001, 5'h00, 2'(i));
      run(14, 16'hc001, 5'h10, 2'(i));
      run(14, 16'h8001, 5'h1f, 2'(i));
      run(2, 16'h0000, 5'h00, 2'(i));
      run(11, 16'h8000, 5'h00, 2'h0);
      run(i[0] ? 13 : 12, 16'h8000, 5'h00, 2'h0);
      run(5, 16'h0000, 5'h00, 2'(i));
      run(18, 16'h0000, 5'h00, 2'h0);
    end
    // Overflow: wrap, sticky, branch clear, then clamp both ways
    run(1, 16'h0000, 5'h00, 2'h1);
    run(14, 16'h7fff, 5'h10, 2'h0);
    run(15, 16'h7fff, 5'h10, 2'h0);
    run(14, 16'h0001, 5'h00, 2'h0);
    run(6, 16'h0000, 5'h00, 2'h0);
    run(1, 16'h0000, 5'h00, 2'h0);
    run(14, 16'h7fff, 5'h10, 2'h0);
    run(15, 16'h7fff, 5'h10, 2'h0);
    run(14, 16'h8000, 5'h10, 2'h0);
    run(16, 16'h7fff, 5'h10, 2'h0);
    run(10, 16'h0000, 5'h00, 2'h0);
    run(7, 16'h0020, 5'h04, 2'h0);
    run(8, 16'h8000, 5'h00, 2'h0);
    run(9, 16'h0000, 5'h11, 2'h0);
    repeat (400)
      run($urandom_range(19, 0), 16'($urandom), 5'($urandom), 2'($urandom));
    do_reset();
    repeat (300)
      run($urandom_range(19, 0), 16'($urandom), 5'($urandom), 2'($urandom));
    run(0, 16'h0000, 5'h00, 2'h0);
    conclude();
  end
endmodule : dss_core_test
